// ---- hdl/isc_consts.svh ----
// Offsets, field positions, reset values and cycle counts of the interrupt and stack control block
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH
`define ISC_NSRC             8
`define ISC_PC_W             13
`define ISC_IO_STATUS        6'h3F
`define ISC_IO_SP_HIGH       6'h3E
`define ISC_IO_SP_LOW        6'h3D
`define ISC_IO_GEN_INT_CTRL  6'h3B
`define ISC_IO_IRQ_ENABLE    6'h3A
`define ISC_IO_IRQ_FLAG      6'h38
`define ISC_GIE_BIT          7
`define ISC_VSEL_BIT         1
`define ISC_SP_RST           16'h0000
`define ISC_STATUS_RST       8'h00
`define ISC_FLAG_SRC_MASK    8'h7F
`define ISC_BOOT_START       13'h1800
`define ISC_VEC_STEP         13'h0002
`define ISC_ENTRY_LAST       3'h3
`define ISC_SLEEP_EXTRA      3'h4
`define ISC_RET_LAST         3'h3
`define ISC_POP_LAST         3'h2
`endif

// ---- hdl/isc_pkg.sv ----
// Types shared by the interrupt and stack control block
`default_nettype none
package isc_pkg;
   typedef enum logic [2:0] {OP_NONE, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_INTERRUPT_RETURN, OP_SEI, OP_CLI} isc_op_t;
   typedef enum logic [2:0] {ST_IDLE, ST_ENTRY, ST_CALL, ST_POP, ST_RET} isc_state_t;
   typedef struct packed {
      logic       we;
      logic       re;
      logic [5:0] addr;
      logic [7:0] wdata;
   } isc_io_req_t;
   typedef struct packed {
      logic        valid;
      isc_op_t     code;
      logic [15:0] data;
   } isc_op_req_t;
   typedef struct packed {
      logic        we;
      logic        re;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } isc_mem_req_t;
endpackage
`default_nettype wire

// ---- hdl/isc_ctrl.sv ----
// Interrupt entry/return sequencing, priority, flags and stack pointer of the CPU core
`timescale 1ns/10ps
`default_nettype none
`include "isc_consts.svh"

module isc_ctrl
   import isc_pkg::*;
(
   input  wire logic                  mclk,
   input  wire logic                  reset,
   input  wire isc_io_req_t           io_req,
   output logic [7:0]                 io_rdata_r,
   input  wire isc_op_req_t           op_req,
   input  wire logic                  insn_done,
   input  wire logic                  sleeping,
   input  wire logic [`ISC_PC_W-1:0]  cur_pc,
   input  wire logic [`ISC_NSRC-1:0]  irq_pin,
   input  wire logic                  boot_reset_fuse,
   input  wire logic                  app_section_lock_bit,
   input  wire logic                  boot_section_lock_bit,
   output isc_mem_req_t               mem_r,
   input  wire logic [7:0]            mem_rdata,
   output logic                       pc_load_r,
   output logic [15:0]                pc_target_r,
   output logic [7:0]                 pop_data_r,
   output logic                       op_done_r,
   output logic                       busy_r,
   output logic [15:0]                reset_vector_r
);

   localparam int PW = `ISC_NSRC + 3;

   isc_state_t                state_r;
   logic [2:0]                cnt_r;
   logic [2:0]                last_r;
   logic [15:0]               stack_pointer_r;
   logic [`ISC_PC_W-1:0]      ret_pc_r;
   logic [`ISC_PC_W-1:0]      vec_r;
   logic                      is_interrupt_return_r;
   logic [7:0]                status_register_r;
   logic                      hold_r;
   logic                      vector_select_r;
   logic [`ISC_NSRC-1:0]      irq_enable_r;
   logic [`ISC_NSRC-1:0]      flag_r;
   logic [`ISC_NSRC-1:0]      src_prev_r;
   logic [PW-1:0]             pin_meta_r;
   logic [PW-1:0]             pin_sync_r;
   logic [`ISC_NSRC-1:0]      src_s;
   logic                      fuse_s;
   logic                      app_lock_s;
   logic                      boot_lock_s;
   logic [`ISC_NSRC-1:0]      req;
   logic [`ISC_NSRC-1:0]      pending;
   logic [`ISC_NSRC-1:0]      win_onehot;
   logic [2:0]                win;
   logic [`ISC_PC_W-1:0]      vec_base;
   logic [`ISC_PC_W-1:0]      vec_addr;
   logic                      in_boot;
   logic                      suppress;
   logic                      idle;
   logic                      op_acc;
   logic                      take;
   logic                      interrupt_return_fin;
   logic                      io_wr;

   // Two-flop synchroniser for all pins; only the second stage is used
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pin_meta_r <= '0;
         pin_sync_r <= '0;
      end else begin
         pin_meta_r <= {boot_section_lock_bit, app_section_lock_bit, boot_reset_fuse, irq_pin};
         pin_sync_r <= pin_meta_r;
      end
   end

   assign src_s       = pin_sync_r[`ISC_NSRC-1:0];
   assign fuse_s      = pin_sync_r[`ISC_NSRC];
   assign app_lock_s  = pin_sync_r[`ISC_NSRC+1];
   assign boot_lock_s = pin_sync_r[`ISC_NSRC+2];
   assign io_wr       = io_req.we;

   // Flag sources use the latch, flagless ones only their live condition
   assign req     = (flag_r & `ISC_FLAG_SRC_MASK) | (src_s & ~`ISC_FLAG_SRC_MASK);
   assign pending = req & irq_enable_r;

   // Lowest index wins, reset being above every source
   always_comb begin
      win = 3'h0;
      for (int i = `ISC_NSRC - 1; i >= 0; i--) begin
         if (pending[i]) begin
            win = 3'(i);
         end
      end
   end

   assign win_onehot = {{(`ISC_NSRC-1){1'b0}}, 1'b1} << win;
   assign vec_base   = vector_select_r ? `ISC_BOOT_START : '0;
   assign vec_addr   = 13'(vec_base + (13'(win) + 13'h0001) * `ISC_VEC_STEP);

   // Lock bits fence interrupts whose vectors lie in the other section
   assign in_boot  = cur_pc >= `ISC_BOOT_START;
   assign suppress = (app_lock_s & ~in_boot & vector_select_r) |
                     (boot_lock_s & in_boot & ~vector_select_r);

   assign idle   = state_r == ST_IDLE;
   assign op_acc = idle & op_req.valid;

   // Taken only at an instruction boundary, so multi-cycle work ends first; any
   // op in the same cycle, a clear-enable among them, wins over the request
   assign take = idle & insn_done & ~op_req.valid & ~hold_r & ~suppress &
                 status_register_r[`ISC_GIE_BIT] & (|pending);

   assign interrupt_return_fin = (state_r == ST_RET) & (cnt_r == `ISC_RET_LAST) & is_interrupt_return_r;

   // Sequencer and stack pointer; all logic sits directly on mclk, no divider
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_r         <= ST_IDLE;
         cnt_r           <= 3'h0;
         last_r          <= 3'h0;
         stack_pointer_r <= `ISC_SP_RST;
         mem_r           <= '0;
         pc_load_r       <= 1'b0;
         pc_target_r     <= 16'h0000;
         pop_data_r      <= 8'h00;
         op_done_r       <= 1'b0;
         busy_r          <= 1'b0;
         ret_pc_r        <= '0;
         vec_r           <= '0;
         is_interrupt_return_r       <= 1'b0;
      end else begin
         mem_r.we  <= 1'b0;
         mem_r.re  <= 1'b0;
         pc_load_r <= 1'b0;
         op_done_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               cnt_r <= 3'h1;
               if (take) begin
                  // Low byte first, at the current pointer
                  mem_r.we        <= 1'b1;
                  mem_r.addr      <= stack_pointer_r;
                  mem_r.wdata     <= cur_pc[7:0];
                  stack_pointer_r <= stack_pointer_r - 16'h0001;
                  ret_pc_r        <= cur_pc;
                  vec_r           <= vec_addr;
                  last_r          <= sleeping ? `ISC_ENTRY_LAST + `ISC_SLEEP_EXTRA : `ISC_ENTRY_LAST;
                  state_r         <= ST_ENTRY;
                  busy_r          <= 1'b1;
               end else if (op_req.valid) begin
                  case (op_req.code)
                     OP_PUSH: begin
                        mem_r.we        <= 1'b1;
                        mem_r.addr      <= stack_pointer_r;
                        mem_r.wdata     <= op_req.data[7:0];
                        stack_pointer_r <= stack_pointer_r - 16'h0001;
                        op_done_r       <= 1'b1;
                     end
                     OP_CALL: begin
                        mem_r.we        <= 1'b1;
                        mem_r.addr      <= stack_pointer_r;
                        mem_r.wdata     <= cur_pc[7:0];
                        stack_pointer_r <= stack_pointer_r - 16'h0001;
                        ret_pc_r        <= cur_pc;
                        vec_r           <= op_req.data[`ISC_PC_W-1:0];
                        state_r         <= ST_CALL;
                        busy_r          <= 1'b1;
                     end
                     OP_POP, OP_RET, OP_INTERRUPT_RETURN: begin
                        mem_r.re        <= 1'b1;
                        mem_r.addr      <= stack_pointer_r + 16'h0001;
                        stack_pointer_r <= stack_pointer_r + 16'h0001;
                        is_interrupt_return_r       <= op_req.code == OP_INTERRUPT_RETURN;
                        state_r         <= (op_req.code == OP_POP) ? ST_POP : ST_RET;
                        busy_r          <= 1'b1;
                     end
                     default: begin
                        op_done_r <= 1'b1;
                     end
                  endcase
               end else if (io_wr && io_req.addr == `ISC_IO_SP_HIGH) begin
                  stack_pointer_r[15:8] <= io_req.wdata;
               end else if (io_wr && io_req.addr == `ISC_IO_SP_LOW) begin
                  stack_pointer_r[7:0] <= io_req.wdata;
               end
            end
            ST_ENTRY: begin
               // High byte goes out with bits 15:13 forced low
               if (cnt_r == 3'h1) begin
                  mem_r.we        <= 1'b1;
                  mem_r.addr      <= stack_pointer_r;
                  mem_r.wdata     <= {3'b000, ret_pc_r[12:8]};
                  stack_pointer_r <= stack_pointer_r - 16'h0001;
               end
               if (cnt_r == last_r) begin
                  pc_load_r   <= 1'b1;
                  pc_target_r <= {3'b000, vec_r};
                  state_r     <= ST_IDLE;
                  busy_r      <= 1'b0;
               end
               cnt_r <= cnt_r + 3'h1;
            end
            ST_CALL: begin
               mem_r.we        <= 1'b1;
               mem_r.addr      <= stack_pointer_r;
               mem_r.wdata     <= {3'b000, ret_pc_r[12:8]};
               stack_pointer_r <= stack_pointer_r - 16'h0001;
               pc_load_r       <= 1'b1;
               pc_target_r     <= {3'b000, vec_r};
               op_done_r       <= 1'b1;
               state_r         <= ST_IDLE;
               busy_r          <= 1'b0;
            end
            ST_POP: begin
               // Memory answers one cycle after the read strobe is seen
               if (cnt_r == `ISC_POP_LAST) begin
                  pop_data_r <= mem_rdata;
                  op_done_r  <= 1'b1;
                  state_r    <= ST_IDLE;
                  busy_r     <= 1'b0;
               end
               cnt_r <= cnt_r + 3'h1;
            end
            ST_RET: begin
               if (cnt_r == 3'h1) begin
                  mem_r.re        <= 1'b1;
                  mem_r.addr      <= stack_pointer_r + 16'h0001;
                  stack_pointer_r <= stack_pointer_r + 16'h0001;
               end
               if (cnt_r == 3'h2) begin
                  ret_pc_r[12:8] <= mem_rdata[4:0];
               end
               if (cnt_r == `ISC_RET_LAST) begin
                  pc_load_r   <= 1'b1;
                  pc_target_r <= {3'b000, ret_pc_r[12:8], mem_rdata};
                  op_done_r   <= 1'b1;
                  state_r     <= ST_IDLE;
                  busy_r      <= 1'b0;
               end
               cnt_r <= cnt_r + 3'h1;
            end
            default: begin
               state_r <= ST_IDLE;
               busy_r  <= 1'b0;
            end
         endcase
      end
   end

   // Only the enable bit is touched by entry and return; the rest is software's
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         status_register_r <= `ISC_STATUS_RST;
      end else if (take) begin
         status_register_r[`ISC_GIE_BIT] <= 1'b0;
      end else if (interrupt_return_fin) begin
         status_register_r[`ISC_GIE_BIT] <= 1'b1;
      end else if (op_acc && op_req.code == OP_SEI) begin
         status_register_r[`ISC_GIE_BIT] <= 1'b1;
      end else if (op_acc && op_req.code == OP_CLI) begin
         status_register_r[`ISC_GIE_BIT] <= 1'b0;
      end else if (io_wr && io_req.addr == `ISC_IO_STATUS) begin
         status_register_r <= io_req.wdata;
      end
   end

   // One instruction must complete after a return or an enable before the next take
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         hold_r <= 1'b0;
      end else if (interrupt_return_fin || (op_acc && op_req.code == OP_SEI)) begin
         hold_r <= 1'b1;
      end else if (insn_done) begin
         hold_r <= 1'b0;
      end
   end

   // Flags: a new edge wins over a same-cycle clear by write or by vectoring
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         flag_r     <= '0;
         src_prev_r <= '0;
      end else begin
         src_prev_r <= src_s;
         flag_r     <= (flag_r & ~((io_wr && io_req.addr == `ISC_IO_IRQ_FLAG ? io_req.wdata : 8'h00) |
                                   (take ? win_onehot & `ISC_FLAG_SRC_MASK : 8'h00))) |
                       (src_s & ~src_prev_r & `ISC_FLAG_SRC_MASK);
      end
   end

   // Software control registers
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         irq_enable_r    <= '0;
         vector_select_r <= 1'b0;
      end else if (io_wr && io_req.addr == `ISC_IO_IRQ_ENABLE) begin
         irq_enable_r <= io_req.wdata;
      end else if (io_wr && io_req.addr == `ISC_IO_GEN_INT_CTRL) begin
         vector_select_r <= io_req.wdata[`ISC_VSEL_BIT];
      end
   end

   // Reset vector follows the synchronised fuse
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         reset_vector_r <= 16'h0000;
      end else begin
         reset_vector_r <= fuse_s ? {3'b000, `ISC_BOOT_START} : 16'h0000;
      end
   end

   // Register reads answer one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         io_rdata_r <= 8'h00;
      end else if (io_req.re) begin
         case (io_req.addr)
            `ISC_IO_STATUS:       io_rdata_r <= status_register_r;
            `ISC_IO_SP_HIGH:      io_rdata_r <= stack_pointer_r[15:8];
            `ISC_IO_SP_LOW:       io_rdata_r <= stack_pointer_r[7:0];
            `ISC_IO_GEN_INT_CTRL: io_rdata_r <= 8'(vector_select_r) << `ISC_VSEL_BIT;
            `ISC_IO_IRQ_ENABLE:   io_rdata_r <= irq_enable_r;
            `ISC_IO_IRQ_FLAG:     io_rdata_r <= flag_r;
            default:              io_rdata_r <= 8'h00;
         endcase
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (reset);

   a_push_dec: assert property (op_acc && op_req.code == OP_PUSH |=>
      stack_pointer_r == $past(stack_pointer_r) - 16'h0001 && mem_r.we && mem_r.addr == $past(stack_pointer_r))
      else $error("push did not store then decrement");
   a_call_dec: assert property (op_acc && op_req.code == OP_CALL |-> ##2
      stack_pointer_r == $past(stack_pointer_r, 2) - 16'h0002 && pc_load_r)
      else $error("call did not lower pointer by two");
   a_pop_inc: assert property (op_acc && op_req.code == OP_POP |=>
      mem_r.re && mem_r.addr == stack_pointer_r && stack_pointer_r == $past(stack_pointer_r) + 16'h0001)
      else $error("pop did not increment then read");
   a_take_gated: assert property (take |-> status_register_r[`ISC_GIE_BIT] && (pending & win_onehot) != 0)
      else $error("interrupt taken without both enables");
   a_entry_time: assert property (take && !sleeping |=> !pc_load_r [*3] ##1
      (pc_load_r && stack_pointer_r == $past(stack_pointer_r, 4) - 16'h0002))
      else $error("entry response not four cycles");
   a_entry_sleep: assert property (take && sleeping |=> !pc_load_r [*7] ##1 pc_load_r)
      else $error("sleep entry response not eight cycles");
   a_interrupt_return_time: assert property (op_acc && op_req.code == OP_INTERRUPT_RETURN |=> !pc_load_r [*3] ##1
      (pc_load_r && status_register_r[`ISC_GIE_BIT] && stack_pointer_r == $past(stack_pointer_r, 4) + 16'h0002))
      else $error("interrupt return not four cycles");
   a_gie_clear: assert property (take |=> !status_register_r[`ISC_GIE_BIT] && busy_r)
      else $error("global enable not cleared on entry");
   a_hold_one: assert property (interrupt_return_fin |=> !take ##1 (!take || $past(insn_done)))
      else $error("interrupt taken right after return");

endmodule
`default_nettype wire

// ---- tb/isc_sram_model.sv ----
// Stack SRAM partner model: synchronous, one-cycle read latency
`timescale 1ns/10ps
`default_nettype none
module isc_sram_model
   import isc_pkg::*;
(
   input  wire logic         mclk,
   input  wire isc_mem_req_t mem_r,
   output logic [7:0]        mem_rdata
);
   logic [7:0] store [logic [15:0]];

   initial begin
      mem_rdata = 8'h00;
   end

   // Data only in the cycle after a read; otherwise it toggles so a sample one cycle late never matches
   always @(posedge mclk) begin
      if (mem_r.we) begin
         store[mem_r.addr] = mem_r.wdata;
      end
      if (mem_r.re && store.exists(mem_r.addr)) begin
         mem_rdata <= store[mem_r.addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule
`default_nettype wire

// ---- tb/tb_isc_ctrl.sv ----
// Self-checking bench for the interrupt and stack control block
`timescale 1ns/10ps
`default_nettype none
`include "isc_consts.svh"
module tb_isc_ctrl
   import isc_pkg::*;
;
   logic         mclk, reset, insn_done, sleeping, boot_reset_fuse, app_lock, boot_lock;
   logic         pc_load_r, op_done_r, busy_r;
   isc_io_req_t  io_req;
   isc_op_req_t  op_req;
   isc_mem_req_t mem_r;
   logic [7:0]   io_rdata_r, irq_pin, mem_rdata, pop_data_r, last_wd;
   logic [12:0]  cur_pc;
   logic [15:0]  pc_target_r, reset_vector_r, last_wa;
   int           error_cnt, checked, lat_n;

   isc_ctrl isc_ctrl_inst (.mclk(mclk), .reset(reset), .io_req(io_req), .io_rdata_r(io_rdata_r),
      .op_req(op_req), .insn_done(insn_done), .sleeping(sleeping), .cur_pc(cur_pc), .irq_pin(irq_pin),
      .boot_reset_fuse(boot_reset_fuse), .app_section_lock_bit(app_lock), .boot_section_lock_bit(boot_lock),
      .mem_r(mem_r), .mem_rdata(mem_rdata), .pc_load_r(pc_load_r), .pc_target_r(pc_target_r),
      .pop_data_r(pop_data_r), .op_done_r(op_done_r), .busy_r(busy_r), .reset_vector_r(reset_vector_r));
   isc_sram_model isc_sram_model_inst (.mclk(mclk), .mem_r(mem_r), .mem_rdata(mem_rdata));

   // Clock, 20 ns period
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Last stack write, caught as soon as it is driven so a check just after the op sees it
   always @(mem_r) begin
      if (mem_r.we) begin
         last_wa = mem_r.addr;
         last_wd = mem_r.wdata;
      end
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge mclk) io_req <= '{1'b1, 1'b0, a, d};
      @(posedge mclk) io_req <= '0;
   endtask

   task automatic io_rd(input logic [5:0] a, input logic [7:0] exp);
      @(posedge mclk) io_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge mclk) io_req <= '0;
      #1 chk(io_rdata_r, exp);
   endtask

   task automatic sp_chk(input logic [15:0] v);
      io_rd(`ISC_IO_SP_HIGH, v[15:8]);
      io_rd(`ISC_IO_SP_LOW, v[7:0]);
   endtask

   // Bounded wait for completion; lat_n counts cycles from the accepting edge
   task automatic op(input isc_op_t c, input logic [15:0] d);
      @(posedge mclk) op_req <= '{1'b1, c, d};
      @(posedge mclk) op_req <= '0;
      lat_n = 1;
      #1;
      while (op_done_r !== 1'b1 && lat_n < 10) begin
         @(posedge mclk);
         #1 lat_n++;
      end
      chk(16'(op_done_r), 16'h0001);
   endtask

   // Instruction boundary; lat 0 means no entry may follow within ten cycles
   task automatic insn(input logic [15:0] vec, input int lat);
      int n;
      @(posedge mclk) insn_done <= 1'b1;
      @(posedge mclk) insn_done <= 1'b0;
      n = 1;
      #1;
      chk(16'(busy_r), 16'(lat != 0));
      while (pc_load_r !== 1'b1 && n < 10) begin
         @(posedge mclk);
         #1 n++;
      end
      chk(16'(n), (lat == 0) ? 16'd10 : 16'(lat));
      if (lat != 0) chk(pc_target_r, vec);
   endtask

   task automatic pulse(input logic [7:0] p);
      @(posedge mclk) irq_pin <= p;
      repeat (4) @(posedge mclk);
      irq_pin <= 8'h00;
      repeat (4) @(posedge mclk);
   endtask

   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      #100000;
      error_cnt++;
      complete_run();
   end

   initial begin
      reset = 1'b1;
      io_req = '0;
      op_req = '0;
      insn_done = 1'b0;
      sleeping = 1'b0;
      cur_pc = 13'h1ABC;
      irq_pin = 8'h00;
      boot_reset_fuse = 1'b0;
      app_lock = 1'b0;
      boot_lock = 1'b0;
      error_cnt = 0;
      checked = 0;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      sp_chk(16'h0000);
      io_rd(`ISC_IO_STATUS, 8'h00);
      chk(reset_vector_r, 16'h0000);
      io_wr(`ISC_IO_SP_HIGH, 8'h02);
      io_wr(`ISC_IO_SP_LOW, 8'h10);
      sp_chk(16'h0210);
      // Byte stack: two pushes, two pops in reverse order
      op(OP_PUSH, 16'h00A5);
      chk({last_wa, last_wd}, {16'h0210, 8'hA5});
      sp_chk(16'h020F);
      op(OP_PUSH, 16'h005A);
      op(OP_POP, 16'h0000);
      chk(pop_data_r, 8'h5A);
      op(OP_POP, 16'h0000);
      chk(pop_data_r, 8'hA5);
      sp_chk(16'h0210);
      // Call and return carry the 13-bit return address
      op(OP_CALL, 16'h0123);
      chk(pc_target_r, 16'h0123);
      chk({last_wa, last_wd}, {16'h020F, 8'h1A});
      sp_chk(16'h020E);
      op(OP_RET, 16'h0000);
      chk(pc_target_r, 16'h1ABC);
      sp_chk(16'h0210);
      // Flags latch while globally disabled, then served by priority
      io_wr(`ISC_IO_STATUS, 8'h01);
      io_wr(`ISC_IO_IRQ_ENABLE, 8'h86);
      pulse(8'h06);
      io_rd(`ISC_IO_IRQ_FLAG, 8'h06);
      insn(16'h0000, 0);
      op(OP_SEI, 16'h0000);
      insn(16'h0000, 0);
      insn(16'h0004, 4);
      io_rd(`ISC_IO_STATUS, 8'h01);
      io_rd(`ISC_IO_IRQ_FLAG, 8'h04);
      sp_chk(16'h020E);
      io_wr(`ISC_IO_STATUS, 8'h02);
      op(OP_INTERRUPT_RETURN, 16'h0000);
      chk(16'(lat_n), 16'd4);
      chk(pc_target_r, 16'h1ABC);
      io_rd(`ISC_IO_STATUS, 8'h82);
      sp_chk(16'h0210);
      insn(16'h0000, 0);
      // Lock bits fence a pending request: boot lock in boot code, app lock in app code
      @(posedge mclk) boot_lock <= 1'b1;
      repeat (3) @(posedge mclk);
      insn(16'h0000, 0);
      @(posedge mclk) boot_lock <= 1'b0;
      repeat (3) @(posedge mclk);
      io_wr(`ISC_IO_GEN_INT_CTRL, 8'h02);
      @(posedge mclk) app_lock <= 1'b1;
      cur_pc <= 13'h0100;
      repeat (3) @(posedge mclk);
      insn(16'h0000, 0);
      @(posedge mclk) app_lock <= 1'b0;
      cur_pc <= 13'h1ABC;
      repeat (3) @(posedge mclk);
      insn(16'h1806, 4);
      op(OP_INTERRUPT_RETURN, 16'h0000);
      // Clear of global enable wins over a request in the same cycle
      pulse(8'h02);
      op(OP_SEI, 16'h0000);
      insn(16'h0000, 0);
      @(posedge mclk) op_req <= '{1'b1, OP_CLI, 16'h0000};
      insn_done <= 1'b1;
      @(posedge mclk) op_req <= '0;
      insn_done <= 1'b0;
      insn(16'h0000, 0);
      io_rd(`ISC_IO_STATUS, 8'h02);
      io_wr(`ISC_IO_IRQ_FLAG, 8'h02);
      io_rd(`ISC_IO_IRQ_FLAG, 8'h00);
      // Flagless source gone before enable gives nothing; present during sleep costs four more
      pulse(8'h80);
      op(OP_SEI, 16'h0000);
      insn(16'h0000, 0);
      insn(16'h0000, 0);
      @(posedge mclk) irq_pin <= 8'h80;
      sleeping <= 1'b1;
      repeat (4) @(posedge mclk);
      insn(16'h1810, 8);
      @(posedge mclk) irq_pin <= 8'h00;
      boot_reset_fuse <= 1'b1;
      repeat (5) @(posedge mclk);
      chk(reset_vector_r, 16'h1800);
      complete_run();
   end
endmodule
`default_nettype wire
